// file: core/irqlp_top.sv
// irqlp_top: interrupt enabling, vector routing and wait/stop sequencing
// assumes: core gives instruction-boundary strobes, peripherals give level flags
// settle count is a parameter so short runs stay short
// wake needs global enable for every source
`default_nettype none

module irqlp_top #(
    parameter int SETTLE_CYC = irqlp_pkg::OSC_SETTLE_CYC
) (
    input  wire logic                     CLK,
    input  wire logic                     RST_N,
    input  wire logic                     WDG_RST,
    input  wire logic [7:0]               ADDR,
    input  wire logic [7:0]               WDATA,
    input  wire logic                     WR,
    input  wire logic                     RD,
    output logic [7:0]                    RDATA,
    input  wire logic                     NMI_PIN_N,
    input  wire logic [7:0]               PORTA_PIN,
    input  wire logic [7:0]               PORTB_PIN,
    input  wire logic [7:0]               PORTC_PIN,
    input  wire logic [7:0]               PORTA_IRQ_EN,
    input  wire logic [7:0]               PORTB_IRQ_EN,
    input  wire logic [7:0]               PORTC_IRQ_EN,
    input  wire irqlp_pkg::irqlp_periph_t PERIPH,
    input  wire logic                     WDG_ACTIVE,
    input  wire logic                     INSTR_END,
    input  wire logic                     WAIT_EXEC,
    input  wire logic                     STOP_EXEC,
    input  wire logic                     VEC_ACK,
    input  wire logic [2:0]               VEC_ACK_NUM,
    input  wire logic                     RETI_EXEC,
    output irqlp_pkg::irqlp_vec_t         IRQ_REQ,
    output logic                          IRQ_TAKE,
    output logic [2:0]                    IRQ_VEC,
    output logic                          FETCH_HALT,
    output logic                          OSC_STOP,
    output logic                          CORE_RESUME,
    output logic                          RST_REQ
);

    // one clock; pins cross in through synchronisers
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_s1_r, rst_s2_r, rst_n;

    // two-stage release of the asynchronous reset
    // entry is immediate, release waits two edges
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // all other processes reset on this copy
    assign rst_n = rst_s2_r;


    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // bit order: nmi, port c, port b, port a
    logic [24:0] pin_s1_r, pin_s2_r, pin_prev_r;
    logic [7:0]  pa, pb, pc, pa_prev, pb_prev, pc_prev;
    logic        nmi_n, nmi_prev_n;

    // every pin passes two flip-flops before use
    // pins idle high: reset high, no false edge
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_r   <= {25{1'b1}};
            pin_s2_r   <= {25{1'b1}};
            pin_prev_r <= {25{1'b1}};
        end else begin
            // third stage keeps the last settled value
            pin_s1_r   <= {NMI_PIN_N, PORTC_PIN, PORTB_PIN, PORTA_PIN};
            pin_s2_r   <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end

    // settled and previous values for edge finders
    assign {nmi_n, pc, pb, pa}                  = pin_s2_r;
    assign {nmi_prev_n, pc_prev, pb_prev, pa_prev} = pin_prev_r;


    // ----------------------------------------
    // option register
    // ----------------------------------------
    logic [7:0] opt_ctrl_r;
    logic       global_irq_enable, source2_polarity_select, source1_trigger_select;

    // whole-byte write only; clears on reset
    // unused bits masked, always zero
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            opt_ctrl_r <= irqlp_pkg::OPT_CTRL_RESET;
        end else if (WR && ADDR == irqlp_pkg::OPT_CTRL_ADDR) begin
            // no read path, so no single-bit update
            opt_ctrl_r <= WDATA & irqlp_pkg::OPT_CTRL_MASK;
        end
    end

    // field decode of the option byte
    assign global_irq_enable       = opt_ctrl_r[irqlp_pkg::GLOBAL_EN_BIT];
    assign source2_polarity_select = opt_ctrl_r[irqlp_pkg::POL2_SEL_BIT];
    assign source1_trigger_select  = opt_ctrl_r[irqlp_pkg::TRIG1_SEL_BIT];


    // ----------------------------------------
    // source detection
    // ----------------------------------------
    logic src1_level, src1_fall, src2_edge, src3_lvl, src4_lvl, nmi_fall;

    // vector one: low level or falling edge on enabled port a/b pins
    // level: any enabled pin held low
    // edge: a high-to-low step on one
    assign src1_level = |((PORTA_IRQ_EN & ~pa) | (PORTB_IRQ_EN & ~pb));
    assign src1_fall  = |((PORTA_IRQ_EN & pa_prev & ~pa) | (PORTB_IRQ_EN & pb_prev & ~pb));

    // vector two: port c edge of selected polarity
    assign src2_edge = source2_polarity_select
        ? |(PORTC_IRQ_EN & ~pc_prev & pc)
        : |(PORTC_IRQ_EN & pc_prev & ~pc);

    // vector four: timer zero or converter end
    // flags are levels until software clears
    assign src4_lvl = (PERIPH.timer_zero_flag & PERIPH.timer_irq_enable)
                    | (PERIPH.conv_end_flag & PERIPH.converter_irq_enable);

    // vector three: reload timer events
    assign src3_lvl = (PERIPH.reload_overflow_flag & PERIPH.reload_overflow_irq_enable)
                    | (PERIPH.reload_compare_flag & PERIPH.reload_compare_irq_enable)
                    | (PERIPH.reload_edge_flag & PERIPH.reload_edge_irq_enable);

    // non-maskable pin: falling edge only
    assign nmi_fall = nmi_prev_n & ~nmi_n;


    // ----------------------------------------
    // edge latches, set wins over clear
    // ----------------------------------------
    logic nmi_lat_r, src1_lat_r, src2_lat_r;
    logic ack0, ack1, ack2;

    // true when the core enters the given vector
    function automatic logic vec_entered(input logic       ack,
                                         input logic [2:0] num,
                                         input logic [2:0] vec);
        return ack && (num == vec);
    endfunction

    // one decode per edge latch
    assign ack0 = vec_entered(VEC_ACK, VEC_ACK_NUM, 3'h0);
    assign ack1 = vec_entered(VEC_ACK, VEC_ACK_NUM, 3'h1);
    assign ack2 = vec_entered(VEC_ACK, VEC_ACK_NUM, 3'h2);

    // latches cleared when the routine starts
    // one edge is kept while a routine runs
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            nmi_lat_r  <= 1'b0;
            src1_lat_r <= 1'b0;
            src2_lat_r <= 1'b0;
        end else begin
            // an edge beside the clear wins
            nmi_lat_r  <= nmi_fall | (nmi_lat_r & ~ack0);
            // held clear in level mode
            src1_lat_r <= (src1_fall & ~source1_trigger_select) | (src1_lat_r & ~ack1 & ~source1_trigger_select);
            src2_lat_r <= src2_edge | (src2_lat_r & ~ack2);
        end
    end


    // ----------------------------------------
    // request gating and vector choice
    // ----------------------------------------
    irqlp_pkg::irqlp_vec_t raw, req;

    // ungated requests, one per vector
    assign raw.v0 = nmi_lat_r;
    // vector one follows the trigger select
    assign raw.v1 = source1_trigger_select ? src1_level : src1_lat_r;
    assign raw.v2 = src2_lat_r;
    assign raw.v3 = src3_lvl;
    assign raw.v4 = src4_lvl;

    // global enable masks all but the non-maskable source
    assign req.v0 = raw.v0;
    assign req.v1 = raw.v1 & global_irq_enable;
    assign req.v2 = raw.v2 & global_irq_enable;
    assign req.v3 = raw.v3 & global_irq_enable;
    assign req.v4 = raw.v4 & global_irq_enable;
    assign IRQ_REQ = req;


    logic        any_mask, wake, run_now;
    irqlp_pkg::irqlp_ctx_t ctx_r;
    irqlp_pkg::irqlp_pwr_t pwr_r;
    assign any_mask = req.v1 | req.v2 | req.v3 | req.v4;

    // wake only when global enable is set
    // a non-maskable request cannot wake without it either
    assign wake = global_irq_enable & (any_mask | req.v0);


    // fixed priority: nmi, then 1..4; maskable only from main context
    always_comb begin
        // defined on every path
        IRQ_VEC = 3'h0;
        if (req.v0 && ctx_r != irqlp_pkg::IRQLP_CTX_NMI)
            IRQ_VEC = 3'h0;
        else if (req.v1)
            IRQ_VEC = 3'h1;
        else if (req.v2)
            IRQ_VEC = 3'h2;
        else if (req.v3)
            IRQ_VEC = 3'h3;
        else
            IRQ_VEC = 3'h4;
    end

    // taken at an instruction end while running
    assign run_now  = (pwr_r == irqlp_pkg::IRQLP_RUN);
    assign IRQ_TAKE = run_now && INSTR_END &&
        ((req.v0 && ctx_r != irqlp_pkg::IRQLP_CTX_NMI) ||
         (any_mask && ctx_r == irqlp_pkg::IRQLP_CTX_MAIN));


    // ----------------------------------------
    // core context tracking
    // ----------------------------------------
    irqlp_pkg::irqlp_ctx_t ctx_ret_r;

    // context follows vector entry and return
    // the non-maskable routine returns to the saved context
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctx_r     <= irqlp_pkg::IRQLP_CTX_MAIN;
            ctx_ret_r <= irqlp_pkg::IRQLP_CTX_MAIN;
        end else if (VEC_ACK) begin
            // remember where we came from
            ctx_ret_r <= ctx_r;
            ctx_r     <= (VEC_ACK_NUM == 3'h0) ? irqlp_pkg::IRQLP_CTX_NMI : irqlp_pkg::IRQLP_CTX_IRQ;
        end else if (RETI_EXEC) begin
            // normal routine always returns to main
            ctx_r     <= (ctx_r == irqlp_pkg::IRQLP_CTX_NMI) ? ctx_ret_r : irqlp_pkg::IRQLP_CTX_MAIN;
            ctx_ret_r <= irqlp_pkg::IRQLP_CTX_MAIN;
        end
    end


    // ----------------------------------------
    // wait / stop sequencer
    // ----------------------------------------
    // wide enough for the full settle count
    logic [$clog2(SETTLE_CYC+1)-1:0] settle_r;
    logic                             resume_r;

    // low-power entry, exit and settle delay
    // entry refused while a request pends
    // stop becomes wait while the watchdog runs
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            pwr_r    <= irqlp_pkg::IRQLP_RUN;
            settle_r <= '0;
            resume_r <= 1'b0;
        end else begin
            resume_r <= 1'b0;
            case (pwr_r)
                // run: watch for wait or stop
                irqlp_pkg::IRQLP_RUN: begin
                    if ((WAIT_EXEC || STOP_EXEC) && !any_mask && !req.v0) begin
                        if (STOP_EXEC && !WDG_ACTIVE)
                            pwr_r <= irqlp_pkg::IRQLP_STOP;
                        else
                            pwr_r <= irqlp_pkg::IRQLP_WAIT;
                    end
                end
                // wait: clock runs, leave on first wake
                irqlp_pkg::IRQLP_WAIT: begin
                    if (wake) begin
                        pwr_r    <= irqlp_pkg::IRQLP_RUN;
                        resume_r <= 1'b1;
                    end
                end
                // stop: oscillator off, load settle count
                irqlp_pkg::IRQLP_STOP: begin
                    if (wake) begin
                        pwr_r    <= irqlp_pkg::IRQLP_SETTLE;
                        settle_r <= SETTLE_CYC[$bits(settle_r)-1:0];
                    end
                end
                // settle: count down, then resume
                irqlp_pkg::IRQLP_SETTLE: begin
                    if (settle_r <= 1) begin
                        pwr_r    <= irqlp_pkg::IRQLP_RUN;
                        resume_r <= 1'b1;
                    end
                    settle_r <= settle_r - 1'b1;
                end
                // unused code: back to run
                default: pwr_r <= irqlp_pkg::IRQLP_RUN;
            endcase
        end
    end

    // core-facing controls from the state
    assign FETCH_HALT  = !run_now;
    // oscillator stop touches no clock source selection
    assign OSC_STOP    = (pwr_r == irqlp_pkg::IRQLP_STOP);
    assign CORE_RESUME = resume_r;
    assign RST_REQ     = WDG_RST;


    // ----------------------------------------
    // read port: option register reads zero
    // ----------------------------------------
    // status: power state and context
    // bits 1:0 power state, bits 3:2 context
    // stands only in the cycle after the strobe
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= irqlp_pkg::RDATA_RESET;
        end else if (RD && ADDR == irqlp_pkg::LP_STATUS_ADDR) begin
            RDATA <= {4'h0, ctx_r, pwr_r};
        end else begin
            RDATA <= irqlp_pkg::RDATA_RESET;
        end
    end
endmodule
`default_nettype wire

// file: inc/irqlp_pkg.sv
// irqlp_pkg: constants and types for the interrupt enable and low-power wake block
// assumes: single clock domain, plain register port from the core
`default_nettype none
package irqlp_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] OPT_CTRL_ADDR   = 8'hc8; // interrupt_option_control, write only
    localparam logic [7:0] OPT_CTRL_RESET  = 8'h00;
    localparam int         TRIG1_SEL_BIT   = 6;     // source1_trigger_select
    localparam int         POL2_SEL_BIT    = 5;     // source2_polarity_select
    localparam int         GLOBAL_EN_BIT   = 4;     // global_irq_enable
    localparam logic [7:0] OPT_CTRL_MASK   = 8'h70;
    // status register of the block's own state, read only
    localparam logic [7:0] LP_STATUS_ADDR  = 8'hcf;
    localparam logic [7:0] RDATA_RESET     = 8'h00;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int          CLK_HZ         = 40_000_000;
    localparam int          OSC_SETTLE_US  = 1000;  // oscillator settle time after stop
    localparam int          OSC_SETTLE_CYC = OSC_SETTLE_US * (CLK_HZ / 1_000_000);

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        IRQLP_RUN,
        IRQLP_WAIT,
        IRQLP_STOP,
        IRQLP_SETTLE
    } irqlp_pwr_t;

    typedef enum logic [1:0] {
        IRQLP_CTX_MAIN,
        IRQLP_CTX_IRQ,
        IRQLP_CTX_NMI
    } irqlp_ctx_t;

    // peripheral events and enables
    typedef struct packed {
        logic       timer_zero_flag;
        logic       timer_irq_enable;
        logic       conv_end_flag;
        logic       converter_irq_enable;
        logic       reload_overflow_flag;
        logic       reload_overflow_irq_enable;
        logic       reload_compare_flag;
        logic       reload_compare_irq_enable;
        logic       reload_edge_flag;
        logic       reload_edge_irq_enable;
    } irqlp_periph_t;

    // per-vector request lines (vector 0 is the non-maskable one)
    typedef struct packed {
        logic       v4;
        logic       v3;
        logic       v2;
        logic       v1;
        logic       v0;
    } irqlp_vec_t;
endpackage
`default_nettype wire

// file: verification/irqlp_core_model.sv
// irqlp_core_model: instruction-sequencing core beside the block
// assumes: one clock; a taken vector is entered only while ack_en is high
`default_nettype none
module irqlp_core_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ack_en,
    input  wire logic       fetch_halt,
    input  wire logic       irq_take,
    input  wire logic [2:0] irq_vec,
    output logic            instr_end,
    output logic            vec_ack,
    output logic [2:0]      vec_ack_num
);
    // an instruction ends each fetching cycle; vector number toggles when idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_end   <= 1'b0;
            vec_ack     <= 1'b0;
            vec_ack_num <= 3'h0;
        end else begin
            instr_end   <= !fetch_halt;
            vec_ack     <= ack_en && irq_take && !vec_ack;
            vec_ack_num <= (ack_en && irq_take) ? irq_vec : ~vec_ack_num;
        end
    end
endmodule
`default_nettype wire

// file: verification/irqlp_top_assertions.sv
// irqlp_top_assertions: port-level checks on masking, routing and wait/stop wake
// assumes: bound into irqlp_top, settle count handed on from the instance
`default_nettype none
module irqlp_top_assertions #(
    parameter int SETTLE_CYC = 4
) (
    input wire logic                     CLK,
    input wire logic                     RST_N,
    input wire logic                     WDG_RST,
    input wire logic [7:0]               ADDR,
    input wire logic [7:0]               WDATA,
    input wire logic                     WR,
    input wire logic                     RD,
    input wire logic [7:0]               RDATA,
    input wire irqlp_pkg::irqlp_periph_t PERIPH,
    input wire logic                     WDG_ACTIVE,
    input wire logic                     WAIT_EXEC,
    input wire logic                     STOP_EXEC,
    input wire irqlp_pkg::irqlp_vec_t    IRQ_REQ,
    input wire logic                     FETCH_HALT,
    input wire logic                     OSC_STOP,
    input wire logic                     CORE_RESUME,
    input wire logic                     RST_REQ
);
    localparam int SETTLE_MAX = SETTLE_CYC + 4;
    logic gen_r;
    logic mask_req;
    // ----
    // shadow of the global enable
    // ----
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            gen_r <= 1'b0;
        else if (WR && ADDR == 8'hc8)
            gen_r <= WDATA[4];
    end
    assign mask_req = IRQ_REQ.v1 | IRQ_REQ.v2 | IRQ_REQ.v3 | IRQ_REQ.v4;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    opt_read_zero_a: assert property (RD && ADDR == 8'hc8 |=> RDATA == 8'h00)
        else $error("option register read not zero");
    vec4_route_a: assert property (IRQ_REQ.v4 == (gen_r && (PERIPH.timer_zero_flag && PERIPH.timer_irq_enable
        || PERIPH.conv_end_flag && PERIPH.converter_irq_enable))) else $error("vector four request wrong");
    vec3_route_a: assert property (IRQ_REQ.v3 == (gen_r && (PERIPH.reload_overflow_flag
        && PERIPH.reload_overflow_irq_enable || PERIPH.reload_compare_flag && PERIPH.reload_compare_irq_enable
        || PERIPH.reload_edge_flag && PERIPH.reload_edge_irq_enable))) else $error("vector three request wrong");
    stop_settle_a: assert property ($fell(OSC_STOP) |-> FETCH_HALT [*2] ##[1:SETTLE_MAX] CORE_RESUME)
        else $error("stop exit without settle");
    wait_resume_a: assert property ($fell(FETCH_HALT) |-> CORE_RESUME)
        else $error("resume pulse missing");
    wdg_no_stop_a: assert property (WDG_ACTIVE && !OSC_STOP |=> !OSC_STOP)
        else $error("oscillator stopped with watchdog on");
    gen_low_hold_a: assert property (FETCH_HALT && !gen_r |=> FETCH_HALT)
        else $error("woke with global enable low");
    pend_block_a: assert property ((WAIT_EXEC || STOP_EXEC) && !FETCH_HALT && mask_req |=> !FETCH_HALT)
        else $error("halted with request pending");
    wait_enter_a: assert property (WAIT_EXEC && !FETCH_HALT && !mask_req && !IRQ_REQ.v0
        |=> FETCH_HALT && !OSC_STOP) else $error("wait not entered");
    rst_echo_a: assert property (RST_REQ == WDG_RST)
        else $error("watchdog reset not passed on");
    cover property (CORE_RESUME);
    cover property ($fell(OSC_STOP));
    cover property (IRQ_REQ.v0 && FETCH_HALT);
endmodule
bind irqlp_top irqlp_top_assertions #(.SETTLE_CYC(SETTLE_CYC)) i_irqlp_top_assertions (
    .CLK(CLK), .RST_N(RST_N), .WDG_RST(WDG_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PERIPH(PERIPH), .WDG_ACTIVE(WDG_ACTIVE), .WAIT_EXEC(WAIT_EXEC),
    .STOP_EXEC(STOP_EXEC), .IRQ_REQ(IRQ_REQ), .FETCH_HALT(FETCH_HALT), .OSC_STOP(OSC_STOP),
    .CORE_RESUME(CORE_RESUME), .RST_REQ(RST_REQ));
`default_nettype wire

// file: verification/test_irqlp_top.sv
// test_irqlp_top: scenarios for masking, routing and wait/stop wake
// assumes: irqlp_top with a settle count of 4 and the core model beside it
`default_nettype none
module test_irqlp_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk = 1'b0, rst_n = 1'b0, wdg_rst = 1'b0, wr_s = 1'b0, rd_s = 1'b0, nmi_n = 1'b1;
    logic       wdg_act = 1'b0, wait_s = 1'b0, stop_s = 1'b0, reti = 1'b0, ack_en = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, porta_pin = 8'hff, portb_pin = 8'hff, portc_pin = 8'hff;
    logic [7:0] porta_en = 8'h00, portb_en = 8'h00, portc_en = 8'h00, rdata;
    logic       irq_take, fetch_halt, osc_stop, core_resume, rst_req, instr_end, vec_ack;
    logic [2:0] irq_vec, vec_ack_num;
    irqlp_pkg::irqlp_periph_t periph = '0;
    irqlp_pkg::irqlp_vec_t    irq_req;
    int         err_count = 0;
    int         samples_checked = 0;
    irqlp_top #(.SETTLE_CYC(4)) i_irqlp_top (
        .CLK(clk), .RST_N(rst_n), .WDG_RST(wdg_rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s),
        .RDATA(rdata), .NMI_PIN_N(nmi_n), .PORTA_PIN(porta_pin), .PORTB_PIN(portb_pin), .PORTC_PIN(portc_pin),
        .PORTA_IRQ_EN(porta_en), .PORTB_IRQ_EN(portb_en), .PORTC_IRQ_EN(portc_en), .PERIPH(periph),
        .WDG_ACTIVE(wdg_act), .INSTR_END(instr_end), .WAIT_EXEC(wait_s), .STOP_EXEC(stop_s), .VEC_ACK(vec_ack),
        .VEC_ACK_NUM(vec_ack_num), .RETI_EXEC(reti), .IRQ_REQ(irq_req), .IRQ_TAKE(irq_take), .IRQ_VEC(irq_vec),
        .FETCH_HALT(fetch_halt), .OSC_STOP(osc_stop), .CORE_RESUME(core_resume), .RST_REQ(rst_req));
    irqlp_core_model i_irqlp_core_model (
        .clk(clk), .rst_n(rst_n), .ack_en(ack_en), .fetch_halt(fetch_halt), .irq_take(irq_take),
        .irq_vec(irq_vec), .instr_end(instr_end), .vec_ack(vec_ack), .vec_ack_num(vec_ack_num));
    // ----
    // shared tasks
    // ----
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic at(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk) wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) addr <= a;
        rd_s <= 1'b1;
        @(posedge clk) rd_s <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic exec(input logic stop);
        @(posedge clk) wait_s <= !stop;
        stop_s <= stop;
        @(posedge clk) wait_s <= 1'b0;
        stop_s <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge clk) rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic finish_test();
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_regs();
        @(posedge clk) periph <= '1;
        #1 chk(8'(irq_req), 8'h00);
        rd(8'hc8, 8'h00);
        rd(8'hcf, 8'h00);
        wr(8'hc8, 8'hff);
        rd(8'hc8, 8'h00);
        rd(8'h3a, 8'h00);
    endtask
    task automatic t_route();
        wr(8'hc8, 8'h10);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk) periph <= 10'h003 << (2 * i);
            #1 chk(8'(irq_req), (i < 3) ? 8'h08 : 8'h10);
            @(posedge clk) periph <= 10'h002 << (2 * i);
            #1 chk(8'(irq_req), 8'h00);
        end
        wr(8'hc8, 8'h00);
        @(posedge clk) periph <= '1;
        #1 chk(8'(irq_req), 8'h00);
        @(posedge clk) periph <= '0;
    endtask
    task automatic t_ports();
        wr(8'hc8, 8'h50);
        @(posedge clk) porta_en <= 8'h01;
        porta_pin <= 8'hfe;
        at(4);
        chk(8'(irq_req), 8'h02);
        @(posedge clk) porta_pin <= 8'hff;
        at(4);
        chk(8'(irq_req), 8'h00);
        wr(8'hc8, 8'h10);
        #1 chk(8'(irq_req), 8'h00);
        @(posedge clk) porta_pin <= 8'hfe;
        at(2);
        @(posedge clk) porta_pin <= 8'hff;
        at(4);
        chk(8'(irq_req), 8'h02);
        do_reset();
        wr(8'hc8, 8'h30);
        @(posedge clk) portc_en <= 8'h04;
        portc_pin <= 8'hfb;
        at(4);
        chk(8'(irq_req), 8'h00);
        @(posedge clk) portc_pin <= 8'hff;
        at(4);
        chk(8'(irq_req), 8'h04);
    endtask
    task automatic t_wait();
        do_reset();
        wr(8'hc8, 8'h10);
        exec(1'b0);
        #1 chk(8'({fetch_halt, osc_stop}), 8'h02);
        rd(8'hcf, 8'h01);
        @(posedge clk) periph <= 10'h300;
        at(1);
        chk(8'({fetch_halt, core_resume}), 8'h01);
        exec(1'b0);
        #1 chk(8'(fetch_halt), 8'h00);
        @(posedge clk) periph <= '0;
    endtask
    task automatic t_stop();
        wr(8'hc8, 8'h50);
        @(posedge clk) wdg_act <= 1'b1;
        exec(1'b1);
        #1 chk(8'({fetch_halt, osc_stop}), 8'h02);
        @(posedge clk) porta_pin <= 8'hfe;
        at(4);
        chk(8'(fetch_halt), 8'h00);
        @(posedge clk) porta_pin <= 8'hff;
        wdg_act <= 1'b0;
        at(4);
        exec(1'b1);
        #1 chk(8'({fetch_halt, osc_stop}), 8'h03);
        @(posedge clk) porta_pin <= 8'hfe;
        for (int n = 0; n < 8 && osc_stop !== 1'b0; n++) at(1);
        chk(8'({osc_stop, fetch_halt}), 8'h01);
        at(2);
        chk(8'(fetch_halt), 8'h01);
        at(4);
        chk(8'(fetch_halt), 8'h00);
        @(posedge clk) porta_pin <= 8'hff;
    endtask
    task automatic t_genlow();
        do_reset();
        wr(8'hc8, 8'h00);
        exec(1'b0);
        @(posedge clk) nmi_n <= 1'b0;
        at(4);
        chk(8'({irq_req.v0, fetch_halt}), 8'h03);
        @(posedge clk) wdg_rst <= 1'b1;
        #1 chk(8'(rst_req), 8'h01);
        @(posedge clk) wdg_rst <= 1'b0;
        nmi_n <= 1'b1;
        do_reset();
        #1 chk(8'({fetch_halt, irq_req.v0}), 8'h00);
    endtask
    task automatic t_ctx();
        wr(8'hc8, 8'h10);
        @(posedge clk) ack_en <= 1'b1;
        periph <= 10'h300;
        #1 chk(8'({irq_take, irq_vec}), 8'h0c);
        at(4);
        @(posedge clk) ack_en <= 1'b0;
        periph <= '0;
        rd(8'hcf, 8'h04);
        exec(1'b0);
        @(posedge clk) periph <= 10'h300;
        at(2);
        rd(8'hcf, 8'h04);
        @(posedge clk) reti <= 1'b1;
        @(posedge clk) reti <= 1'b0;
        periph <= '0;
        rd(8'hcf, 8'h00);
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    // watchdog cuts a hang short
    initial begin
        #50us;
        err_count++;
        finish_test();
    end
    initial begin
        do_reset();
        t_regs();
        t_route();
        t_ports();
        t_wait();
        t_stop();
        t_genlow();
        t_ctx();
        finish_test();
    end
endmodule
`default_nettype wire
